// >>> rtl/dtcs_pkg.sv
// Purpose: constants for the transfer channel status block
// Assumes: 32-bit AHB-Lite register access, one clock
// Notes:   byte offsets are word aligned
package dtcs_pkg;
  localparam logic [11:0] STATUS_OFFSET   = 12'h100;
  localparam logic [11:0] DEPTH_OFFSET    = 12'h004;
  localparam int          HEAD_LSB        = 11;
  localparam int          RSVD_ONE_BIT    = 8;
  localparam int          OCC_LSB         = 4;
  localparam int          WPEND_BIT       = 2;
  localparam int          SRC_BIT         = 1;
  localparam int          PROG_BIT        = 0;
  localparam int          DEPTH_LSB       = 8;
  localparam logic [1:0]  DEPTH_CODE      = 2'h2;
  localparam logic [2:0]  FIFO_ENTRIES    = 3'h4;
  localparam logic [1:0]  HEAD_RESET      = 2'h0;
  localparam logic [2:0]  OCC_RESET       = 3'h0;
  localparam logic [7:0]  WPEND_RESET     = 8'h00;
  localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;
  typedef enum logic [1:0] {
    SRC_IDLE = 2'b01,
    SRC_BUSY = 2'b10
  } dtcs_src_state_t;
endpackage

// >>> rtl/dtcs_status.sv
// Purpose: occupancy and busy tracking of a transfer channel, with status
//          readable over AHB-Lite
// Assumes: controller pulses are single-cycle, same clock domain
// Notes:   status word read-only; configuration word carries depth code
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
module dtcs_status
  import dtcs_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        prog_write,
  input  wire logic        source_done,
  input  wire logic        head_done,
  input  wire logic        write_issue,
  input  wire logic        write_response,
  output logic             program_set_occupied,
  output logic             source_side_busy,
  output logic             write_response_pending,
  output logic [2:0]       dest_fifo_occupancy,
  output logic [1:0]       dest_fifo_head_index,
  output logic             accept_ready
);
  import dtcs_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // request movement
  logic            prog_q;
  dtcs_src_state_t src_q;
  logic [2:0]      occ_q;
  logic [1:0]      head_q;
  logic [7:0]      wpend_q;
  logic [7:0]      wpend_d;
  logic            wpend_flag_q;
  logic            fifo_empty;
  logic            fifo_full;
  logic            move;
  logic            pop;
  logic [31:0]     status_word;

  assign fifo_empty = (occ_q == OCC_RESET);
  assign fifo_full  = (occ_q == FIFO_ENTRIES);
  assign pop        = head_done && !fifo_empty;
  // move into destination FIFO; full blocks entry
  assign move = prog_q && (fifo_empty
                || (!fifo_full && src_q == SRC_IDLE));
  assign accept_ready = !prog_q;

  // program set holds one request until it moves on
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      prog_q <= 1'b0;
    else if (prog_write && !prog_q)
      prog_q <= 1'b1;
    else if (move)
      prog_q <= 1'b0;
  end

  // source side services each request that moves on while it is idle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      src_q <= SRC_IDLE;
    else
    begin
      case (src_q)
        SRC_IDLE: if (move) src_q <= SRC_BUSY;
        SRC_BUSY: if (source_done) src_q <= SRC_IDLE;
        default:  src_q <= SRC_IDLE;
      endcase
    end
  end

  // occupancy counter, capped at four entries
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      occ_q <= OCC_RESET;
    else if (move && !pop)
      occ_q <= occ_q + 3'h1;
    else if (pop && !move)
      occ_q <= occ_q - 3'h1;
  end

  // head index advances as the head request completes
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      head_q <= HEAD_RESET;
    else if (pop)
      head_q <= head_q + 2'h1;
  end

  // outstanding write responses; a reply with nothing pending is dropped,
  // and more than 255 outstanding writes wrap the count
  always_comb
  begin
    wpend_d = wpend_q;
    if (write_issue && !(write_response && wpend_q != WPEND_RESET))
      wpend_d = wpend_q + 8'h01;
    else if (!write_issue && write_response && wpend_q != WPEND_RESET)
      wpend_d = wpend_q - 8'h01;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      wpend_q <= WPEND_RESET;
    else
      wpend_q <= wpend_d;
  end

  // pending flag in its own flop so the status output is registered
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      wpend_flag_q <= 1'b0;
    else
      wpend_flag_q <= (wpend_d != WPEND_RESET);
  end

  assign program_set_occupied   = prog_q;
  assign source_side_busy       = (src_q == SRC_BUSY);
  assign write_response_pending = wpend_flag_q;
  assign dest_fifo_occupancy    = occ_q;
  assign dest_fifo_head_index   = head_q;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[HEAD_LSB +: 2]  = head_q;
    status_word[RSVD_ONE_BIT]   = 1'b1;
    status_word[OCC_LSB +: 3]   = occ_q;
    status_word[WPEND_BIT]      = write_response_pending;
    status_word[SRC_BIT]        = source_side_busy;
    status_word[PROG_BIT]       = prog_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait, always OKAY, writes ignored
  logic rd_go;
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      hrdata <= RDATA_RESET;
    else if (rd_go)
    begin
      if (haddr == STATUS_OFFSET)
        hrdata <= status_word;
      else if (haddr == DEPTH_OFFSET)
        hrdata <= {22'h0, DEPTH_CODE, 8'h00};
      else
        hrdata <= RDATA_RESET;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  // occupancy and head index
  occ_range_a: assert property (@(posedge clock)
    disable iff (!rstn) occ_q <= FIFO_ENTRIES)
    else $error("occupancy above four");

  occ_step_a: assert property (@(posedge clock)
    disable iff (!rstn) move && !pop |=> occ_q == $past(occ_q) + 3'h1)
    else $error("occupancy did not count a move");

  occ_hold_a: assert property (@(posedge clock)
    disable iff (!rstn) !move && !pop |=> $stable(occ_q))
    else $error("occupancy changed without cause");

  head_step_a: assert property (@(posedge clock)
    disable iff (!rstn) pop |=> head_q == $past(head_q) + 2'h1)
    else $error("head index did not advance");

  head_hold_a: assert property (@(posedge clock)
    disable iff (!rstn) !pop |=> $stable(head_q))
    else $error("head index moved without completion");

  // request movement into the destination fifo
  empty_move_a: assert property (@(posedge clock)
    disable iff (!rstn) prog_q && fifo_empty |=> !prog_q && occ_q == 3'h1)
    else $error("empty fifo did not take request");

  busy_hold_a: assert property (@(posedge clock)
    disable iff (!rstn)
    prog_q && !fifo_empty && src_q == SRC_BUSY |=> prog_q)
    else $error("request moved while source busy");

  partial_move_a: assert property (@(posedge clock)
    disable iff (!rstn)
    prog_q && !fifo_empty && !fifo_full && src_q == SRC_IDLE |=> !prog_q)
    else $error("partly filled fifo did not take request");

  full_hold_a: assert property (@(posedge clock)
    disable iff (!rstn) fifo_full && !pop |=> occ_q == FIFO_ENTRIES)
    else $error("full fifo changed without completion");

  full_block_a: assert property (@(posedge clock)
    disable iff (!rstn) prog_q && fifo_full |=> prog_q)
    else $error("request entered a full fifo");

  // write responses, source side and program set
  wpend_bit_a: assert property (@(posedge clock)
    disable iff (!rstn) write_issue |=> write_response_pending)
    else $error("write pending not set");

  wpend_clear_a: assert property (@(posedge clock)
    disable iff (!rstn)
    wpend_q == 8'h01 && write_response && !write_issue
      |=> !write_response_pending)
    else $error("write pending not cleared");

  src_busy_a: assert property (@(posedge clock)
    disable iff (!rstn) move && src_q == SRC_IDLE |=> source_side_busy)
    else $error("source not busy after move");

  src_idle_a: assert property (@(posedge clock)
    disable iff (!rstn)
    source_side_busy && source_done |=> !source_side_busy)
    else $error("source still busy after done");

  prog_set_a: assert property (@(posedge clock)
    disable iff (!rstn) prog_write && !prog_q |=> program_set_occupied)
    else $error("program set not occupied");

  prog_clear_a: assert property (@(posedge clock)
    disable iff (!rstn) move |=> !program_set_occupied)
    else $error("program set not freed");

  // read data of the status, depth and unmapped words; writes ignored
  status_read_a: assert property (@(posedge clock)
    disable iff (!rstn) rd_go && haddr == STATUS_OFFSET |=>
      hrdata[RSVD_ONE_BIT] && hrdata[31:13] == 19'h0)
    else $error("status constant bits wrong");

  head_field_a: assert property (@(posedge clock)
    disable iff (!rstn) rd_go && haddr == STATUS_OFFSET |=>
      hrdata[HEAD_LSB +: 2] == $past(head_q))
    else $error("head field wrong");

  occ_field_a: assert property (@(posedge clock)
    disable iff (!rstn) rd_go && haddr == STATUS_OFFSET |=>
      hrdata[OCC_LSB +: 3] == $past(occ_q))
    else $error("occupancy field wrong");

  wpend_field_a: assert property (@(posedge clock)
    disable iff (!rstn) rd_go && haddr == STATUS_OFFSET |=>
      hrdata[WPEND_BIT] == $past(write_response_pending))
    else $error("write pending field wrong");

  src_field_a: assert property (@(posedge clock)
    disable iff (!rstn) rd_go && haddr == STATUS_OFFSET |=>
      hrdata[SRC_BIT] == $past(source_side_busy))
    else $error("source field wrong");

  prog_field_a: assert property (@(posedge clock)
    disable iff (!rstn) rd_go && haddr == STATUS_OFFSET |=>
      hrdata[PROG_BIT] == $past(prog_q))
    else $error("program set field wrong");

  rsvd_zero_a: assert property (@(posedge clock)
    disable iff (!rstn) rd_go && haddr == STATUS_OFFSET |=>
      hrdata[10:9] == 2'h0 && !hrdata[7] && !hrdata[3])
    else $error("unused status bits not zero");

  unmapped_zero_a: assert property (@(posedge clock)
    disable iff (!rstn) rd_go && haddr != STATUS_OFFSET &&
      haddr != DEPTH_OFFSET |=> hrdata == RDATA_RESET)
    else $error("unmapped read not zero");

  write_ignored_a: assert property (@(posedge clock)
    disable iff (!rstn) hsel && hready && htrans[1] && hwrite |=>
      $stable(hrdata))
    else $error("write changed read data");

  depth_read_a: assert property (@(posedge clock)
    disable iff (!rstn) rd_go && haddr == DEPTH_OFFSET |=>
      hrdata[DEPTH_LSB +: 2] == DEPTH_CODE)
    else $error("depth code wrong");

  depth_rest_a: assert property (@(posedge clock)
    disable iff (!rstn) rd_go && haddr == DEPTH_OFFSET |=>
      hrdata[31:10] == 22'h0 && hrdata[7:0] == 8'h00)
    else $error("depth word other bits not zero");

  fill_c: cover property (@(posedge clock) disable iff (!rstn) fifo_full);
  drain_c: cover property (@(posedge clock) disable iff (!rstn)
    fifo_full ##[1:50] fifo_empty);
  block_c: cover property (@(posedge clock) disable iff (!rstn)
    prog_q && fifo_full);
  partial_c: cover property (@(posedge clock) disable iff (!rstn)
    prog_q && !fifo_empty && !fifo_full && src_q == SRC_IDLE);
  wpend_c: cover property (@(posedge clock) disable iff (!rstn)
    write_issue && write_response && write_response_pending);
endmodule

// >>> testbench/dtcs_ctrl_model.sv
// Purpose: channel controller that submits transfer requests
// Assumes: one-cycle prog_write pulses, same clock as the block
// Notes:   go enables submission; one request per free program set
module dtcs_ctrl_model
(
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic go,
  input  wire logic accept_ready,
  output logic      prog_write
);
  timeunit 1ns;
  timeprecision 1ps;
  // no back-to-back pulse: occupied shows one cycle after the request
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      prog_write <= 1'b0;
    else
      prog_write <= go && accept_ready && !prog_write;
endmodule

// >>> testbench/tb_dma_tc_channel_status.sv
// Purpose: self-checking bench for the channel status block
// Assumes: zero-wait AHB-Lite slave, controller model on the far side
// Notes:   expected status words are built from field positions
module tb_dma_tc_channel_status;
  timeunit 1ns;
  timeprecision 1ps;
  import dtcs_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        program_set_occupied;
  logic        source_side_busy;
  logic        write_response_pending;
  logic [2:0]  dest_fifo_occupancy;
  logic [1:0]  dest_fifo_head_index;
  logic        prog_write;
  logic        accept_ready;
  logic        go = 1'b0;
  logic [3:0]  ev = 4'h0;
  logic [31:0] rd;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #4 clock = ~clock;
  dtcs_status dut_u (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata),
    .prog_write(prog_write), .source_done(ev[0]), .head_done(ev[1]),
    .write_issue(ev[2]), .write_response(ev[3]),
    .program_set_occupied(program_set_occupied),
    .source_side_busy(source_side_busy),
    .write_response_pending(write_response_pending),
    .dest_fifo_occupancy(dest_fifo_occupancy),
    .dest_fifo_head_index(dest_fifo_head_index),
    .accept_ready(accept_ready));
  dtcs_ctrl_model ctrl_u (.clock(clock), .rstn(rstn), .go(go),
    .accept_ready(accept_ready), .prog_write(prog_write));
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one single word transfer; waits for hready in both phases
  task automatic bus(input logic [11:0] a, input logic w,
                     input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsize <= HSIZE_WORD;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic st(input logic [1:0] hd, input logic [2:0] oc,
                    input logic wp, input logic sb, input logic pb);
    bus(STATUS_OFFSET, 1'b0, 32'h0);
    chk(rd, {19'h0, hd, 3'h1, 1'b0, oc, 1'b0, wp, sb, pb});
    // direct status outputs and the bus response must agree
    chk({23'h0, hresp, dest_fifo_head_index, dest_fifo_occupancy,
         write_response_pending, source_side_busy, program_set_occupied},
        {23'h0, 1'b0, hd, oc, wp, sb, pb});
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= 4'h0;
    repeat (5) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    st(2'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    bus(DEPTH_OFFSET, 1'b0, 32'h0);
    chk(rd, {22'h0, DEPTH_CODE, 8'h0});
    bus(12'h008, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(STATUS_OFFSET, 1'b1, 32'hffff_ffff);
    st(2'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    $display("registers done");
  endtask
  task automatic t_fifo();
    @(posedge clock);
    go <= 1'b1;
    repeat (6) @(posedge clock);
    st(2'h0, 3'h1, 1'b0, 1'b1, 1'b1);
    pulse(4'h1);
    st(2'h0, 3'h2, 1'b0, 1'b1, 1'b1);
    pulse(4'h1);
    pulse(4'h1);
    st(2'h0, 3'h4, 1'b0, 1'b1, 1'b1);
    pulse(4'h1);
    st(2'h0, 3'h4, 1'b0, 1'b0, 1'b1);
    go <= 1'b0;
    pulse(4'h2);
    st(2'h1, 3'h4, 1'b0, 1'b1, 1'b0);
    $display("fifo done");
  endtask
  task automatic t_wpend();
    pulse(4'h4);
    pulse(4'h4);
    pulse(4'h8);
    st(2'h1, 3'h4, 1'b1, 1'b1, 1'b0);
    pulse(4'hc);
    pulse(4'h8);
    st(2'h1, 3'h4, 1'b0, 1'b1, 1'b0);
    $display("write status done");
  endtask
  task automatic t_reset();
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    st(2'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    $display("reset done");
  endtask
  initial
  begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    t_fifo();
    t_wpend();
    t_reset();
    stop_test();
  end
endmodule
